// >>> srwp_pkg.sv
// shared constants for the status register write protect block
package srwp_pkg;
  // write-status-register opcodes
  localparam logic [7:0] SRWP_OP_WRSR0 = 8'h01;
  localparam logic [7:0] SRWP_OP_WRSR2 = 8'h31;
  localparam logic [7:0] SRWP_OP_WRSR3 = 8'h11;
  localparam logic [7:0] SRWP_OP_WRSR4 = 8'h71;
  // status register index written by each opcode
  localparam logic [1:0] SRWP_IDX_SR0 = 2'h0;
  localparam logic [1:0] SRWP_IDX_SR2 = 2'h1;
  localparam logic [1:0] SRWP_IDX_SR3 = 2'h2;
  localparam logic [1:0] SRWP_IDX_SR4 = 2'h3;
  // field positions inside the written data byte
  localparam int SRWP_LO_POS = 7;
  localparam int SRWP_HI_POS = 0;
  // values after reset; all-protected until the reload has run
  localparam logic SRWP_HI_RST = 1'h1;
  localparam logic SRWP_LO_RST = 1'h1;
  localparam logic [7:0] SRWP_BYTE_RST = 8'h00;
  localparam logic [1:0] SRWP_PAIR_SW = 2'h0;
  localparam logic [1:0] SRWP_PAIR_HW = 2'h1;
  localparam logic [1:0] SRWP_PAIR_LOCKDOWN = 2'h2;
  localparam logic [1:0] SRWP_PAIR_BOTH = 2'h3;
  // sequencer states, one-hot
  typedef enum logic [2:0] {
    SRWP_S_LOAD = 3'h1,
    SRWP_S_IDLE = 3'h2,
    SRWP_S_EXEC = 3'h4
  } srwp_state_t;
endpackage

// >>> srwp_sync2.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
module srwp_sync2 #(
  parameter logic RST_VAL = 1'h0
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // level in and out
  input wire logic d,
  output logic q
);
  logic meta_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// >>> srwp_link.sv
// link-side capture of write-status-register commands on the spi clock
`timescale 1ns/1ps
module srwp_link
  import srwp_pkg::*;
(
  // link clock and reset
  input wire logic spi_clk,
  input wire logic reset,
  // command from the link decoder
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_opcode,
  input wire logic [7:0] cmd_data,
  // handshake with the system domain
  input wire logic ack_sync,
  output logic req_tgl_q,
  output logic [7:0] op_q,
  output logic [7:0] data_q,
  output logic busy_q
);
  logic take;
  logic busy_d;

  // a command while one is in flight is dropped; op and data must stay still
  assign take = cmd_valid && !busy_q;
  assign busy_d = take || (req_tgl_q != ack_sync);

  always_ff @(posedge spi_clk or posedge reset) begin
    if (reset) begin
      req_tgl_q <= 1'h0;
      op_q <= SRWP_BYTE_RST;
      data_q <= SRWP_BYTE_RST;
      busy_q <= 1'h0;
    end else begin
      busy_q <= busy_d;
      if (take) begin
        req_tgl_q <= !req_tgl_q;
        op_q <= cmd_opcode;
        data_q <= cmd_data;
      end
    end
  end
endmodule

// >>> srwp_top.sv
// status register write protect: decision, reload on reset, link crossing
// How it works
// - both bits zero, enabled write is accepted
// - both bits zero, pin level is ignored
// - bits 0,1 and pin low refuse writes
// - bits 0,1 and pin high allow writes
// - bits 1,0 block writes until reset
// - bits 1,1 unlocked block until reset
// - bits 1,1 locked block writes forever
// - reload 0,0 gives 0,0
// - reload 0,1 gives 0,1
// - reload 1,0 gives 0,0
// - reload 1,1 unlocked gives 0,1
// - reload 1,1 locked keeps 1,1
// - high bit is status register 2 bit 0
`timescale 1ns/1ps
module srwp_top
  import srwp_pkg::*;
(
  // system clock and power-on reset
  input wire logic sys_clk,
  input wire logic reset,
  // spi link
  input wire logic spi_clk,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_opcode,
  input wire logic [7:0] cmd_data,
  output logic link_busy,
  // pins
  input wire logic wp_pin_n,
  input wire logic hw_reset_pin_n,
  // control from the rest of the device
  input wire logic sw_reset,
  input wire logic write_enable_latch,
  input wire logic nv_protect_mode_hi,
  input wire logic nv_protect_mode_lo,
  input wire logic permanent_lock_bit,
  // status
  output logic protect_mode_hi,
  output logic protect_mode_lo,
  output logic status_write_allowed,
  output logic reload_busy,
  // result of each command
  output logic cmd_done,
  output logic cmd_accepted,
  output logic sr_wr_pulse,
  output logic [1:0] sr_wr_index,
  output logic [7:0] sr_wr_data
);
  import srwp_pkg::*;

  // decides whether status writes are open for the current protect state
  function automatic logic wr_open(input logic hi, input logic lo, input logic lock,
                                   input logic wp_high);
    logic open;
    open = 1'h0;
    case ({hi, lo})
      SRWP_PAIR_SW: open = 1'h1;
      SRWP_PAIR_HW: open = wp_high;
      SRWP_PAIR_LOCKDOWN: open = 1'h0;
      default: open = 1'h0;
    endcase
    if (lock && hi && lo) begin
      open = 1'h0;
    end
    return open;
  endfunction

  // volatile pair loaded from the non-volatile copy on any reset
  function automatic logic [1:0] reload_pair(input logic nv_hi, input logic nv_lo,
                                             input logic lock);
    logic [1:0] pair;
    pair = SRWP_PAIR_SW;
    case ({nv_hi, nv_lo})
      SRWP_PAIR_SW: pair = SRWP_PAIR_SW;
      SRWP_PAIR_HW: pair = SRWP_PAIR_HW;
      SRWP_PAIR_LOCKDOWN: pair = SRWP_PAIR_SW;
      default: pair = lock ? SRWP_PAIR_BOTH : SRWP_PAIR_HW;
    endcase
    return pair;
  endfunction

  // maps a write-status opcode to its register; valid low for other opcodes
  function automatic logic [2:0] op_decode(input logic [7:0] op);
    logic [2:0] r;
    r = 3'h0;
    if (op == SRWP_OP_WRSR0) begin
      r = {1'h1, SRWP_IDX_SR0};
    end else if (op == SRWP_OP_WRSR2) begin
      r = {1'h1, SRWP_IDX_SR2};
    end else if (op == SRWP_OP_WRSR3) begin
      r = {1'h1, SRWP_IDX_SR3};
    end else if (op == SRWP_OP_WRSR4) begin
      r = {1'h1, SRWP_IDX_SR4};
    end
    return r;
  endfunction

  // crossing wires
  logic req_tgl;
  logic [7:0] link_op;
  logic [7:0] link_data;
  logic req_sync;
  logic ack_tgl_q;
  logic ack_sync;
  logic wp_high;
  logic hw_rst_n_sync;

  srwp_link u_link (
    .spi_clk(spi_clk),
    .reset(reset),
    .cmd_valid(cmd_valid),
    .cmd_opcode(cmd_opcode),
    .cmd_data(cmd_data),
    .ack_sync(ack_sync),
    .req_tgl_q(req_tgl),
    .op_q(link_op),
    .data_q(link_data),
    .busy_q(link_busy)
  );

  srwp_sync2 #(.RST_VAL(1'h0)) u_req_sync (
    .clk(sys_clk),
    .reset(reset),
    .d(req_tgl),
    .q(req_sync)
  );

  srwp_sync2 #(.RST_VAL(1'h0)) u_ack_sync (
    .clk(spi_clk),
    .reset(reset),
    .d(ack_tgl_q),
    .q(ack_sync)
  );

  // pin held low at reset reads as protected until the synchroniser fills
  srwp_sync2 #(.RST_VAL(1'h0)) u_wp_sync (
    .clk(sys_clk),
    .reset(reset),
    .d(wp_pin_n),
    .q(wp_high)
  );

  srwp_sync2 #(.RST_VAL(1'h0)) u_hwrst_sync (
    .clk(sys_clk),
    .reset(reset),
    .d(hw_reset_pin_n),
    .q(hw_rst_n_sync)
  );

  // state
  srwp_state_t st_q, st_d;
  logic hi_q, hi_d;
  logic lo_q, lo_d;
  logic seen_q;
  logic [7:0] op_hold_q;
  logic [7:0] data_hold_q;
  logic open_q;
  logic done_q, acc_q, wr_q;
  logic [1:0] idx_q;
  logic [7:0] wr_data_q;

  // decode
  logic reset_evt;
  logic req_new;
  logic open_now;
  logic [1:0] reload_now;
  logic [2:0] dec;
  logic is_wrsr;
  logic accept;
  logic in_exec;

  assign reset_evt = sw_reset || !hw_rst_n_sync;
  assign req_new = req_sync != seen_q;
  assign open_now = wr_open(hi_q, lo_q, permanent_lock_bit, wp_high);
  assign reload_now = reload_pair(nv_protect_mode_hi, nv_protect_mode_lo, permanent_lock_bit);
  assign dec = op_decode(op_hold_q);
  assign is_wrsr = dec[2];
  assign in_exec = (st_q == SRWP_S_EXEC) && !reset_evt;
  // refused or non-write commands still finish, with nothing changed
  assign accept = in_exec && is_wrsr && write_enable_latch && open_now;

  always_comb begin
    st_d = st_q;
    case (st_q)
      SRWP_S_LOAD: begin
        if (!reset_evt) begin
          st_d = SRWP_S_IDLE;
        end
      end
      SRWP_S_IDLE: begin
        if (reset_evt) begin
          st_d = SRWP_S_LOAD;
        end else if (req_new) begin
          st_d = SRWP_S_EXEC;
        end
      end
      SRWP_S_EXEC: begin
        st_d = reset_evt ? SRWP_S_LOAD : SRWP_S_IDLE;
      end
      default: st_d = SRWP_S_LOAD;
    endcase
  end

  // reload wins over any write; lockdown is lifted only here
  always_comb begin
    hi_d = hi_q;
    lo_d = lo_q;
    if (st_q == SRWP_S_LOAD) begin
      hi_d = reload_now[1];
      lo_d = reload_now[0];
    end else if (accept && dec[1:0] == SRWP_IDX_SR0) begin
      lo_d = data_hold_q[SRWP_LO_POS];
    end else if (accept && dec[1:0] == SRWP_IDX_SR2) begin
      hi_d = data_hold_q[SRWP_HI_POS];
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_q <= SRWP_S_LOAD;
      hi_q <= SRWP_HI_RST;
      lo_q <= SRWP_LO_RST;
    end else begin
      st_q <= st_d;
      hi_q <= hi_d;
      lo_q <= lo_d;
    end
  end

  // link handshake; held bytes are stable while the toggle is pending
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      seen_q <= 1'h0;
      ack_tgl_q <= 1'h0;
      op_hold_q <= SRWP_BYTE_RST;
      data_hold_q <= SRWP_BYTE_RST;
    end else begin
      if (st_q == SRWP_S_IDLE && !reset_evt && req_new) begin
        seen_q <= req_sync;
        op_hold_q <= link_op;
        data_hold_q <= link_data;
      end
      if (st_q == SRWP_S_EXEC) begin
        ack_tgl_q <= seen_q;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      done_q <= 1'h0;
      acc_q <= 1'h0;
      wr_q <= 1'h0;
      idx_q <= SRWP_IDX_SR0;
      wr_data_q <= SRWP_BYTE_RST;
      open_q <= 1'h0;
    end else begin
      done_q <= st_q == SRWP_S_EXEC;
      acc_q <= accept;
      wr_q <= accept;
      open_q <= open_now && (st_q != SRWP_S_LOAD);
      if (accept) begin
        idx_q <= dec[1:0];
        wr_data_q <= data_hold_q;
      end
    end
  end

  assign protect_mode_hi = hi_q;
  assign protect_mode_lo = lo_q;
  assign status_write_allowed = open_q;
  // one-hot load bit, so the output is the state flop itself
  assign reload_busy = st_q[0];
  assign cmd_done = done_q;
  assign cmd_accepted = acc_q;
  assign sr_wr_pulse = wr_q;
  assign sr_wr_index = idx_q;
  assign sr_wr_data = wr_data_q;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  logic ok_req;
  assign ok_req = in_exec && is_wrsr && write_enable_latch;

  sw_open_a: assert property (ok_req && !hi_q && !lo_q |=> sr_wr_pulse && cmd_accepted)
    else $error("software-protected write not accepted");
  pin_ignored_a: assert property (!hi_q && !lo_q && ok_req && !wp_high |=> sr_wr_pulse)
    else $error("pin level blocked a software-protected write");
  hw_block_a: assert property (in_exec && !hi_q && lo_q && !wp_high |=> !sr_wr_pulse)
    else $error("write passed hardware protection");
  hw_open_a: assert property (ok_req && !hi_q && lo_q && wp_high |=> sr_wr_pulse)
    else $error("hardware-unprotected write refused");
  lockdown_a: assert property (in_exec && hi_q && !lo_q |=> !sr_wr_pulse ##0 $stable(lo_q))
    else $error("write passed reset lockdown");
  lockdown_both_a: assert property (in_exec && hi_q && lo_q && !permanent_lock_bit
                                    |=> !sr_wr_pulse && hi_q && lo_q)
    else $error("write passed unlocked 1,1 lockdown");
  otp_hold_a: assert property (hi_q && lo_q && permanent_lock_bit && $stable(permanent_lock_bit)
                               |=> hi_q && lo_q)
    else $error("permanent protection lifted");
  rel_sw_a: assert property (reload_busy && !nv_protect_mode_hi && !nv_protect_mode_lo
                             |=> !hi_q && !lo_q)
    else $error("reload of 0,0 wrong");
  rel_hw_a: assert property (reload_busy && !nv_protect_mode_hi && nv_protect_mode_lo
                             |=> !hi_q && lo_q)
    else $error("reload of 0,1 wrong");
  rel_lockdown_a: assert property (reload_busy && nv_protect_mode_hi && !nv_protect_mode_lo
                                   |=> !hi_q && !lo_q)
    else $error("reload of 1,0 wrong");
  rel_both_a: assert property (reload_busy && nv_protect_mode_hi && nv_protect_mode_lo
                               && !permanent_lock_bit |=> !hi_q && lo_q)
    else $error("reload of unlocked 1,1 wrong");
  rel_otp_a: assert property (reload_busy && nv_protect_mode_hi && nv_protect_mode_lo
                              && permanent_lock_bit |=> hi_q && lo_q)
    else $error("reload of locked 1,1 wrong");
  hi_field_a: assert property (accept && dec[1:0] == SRWP_IDX_SR2
                               |=> hi_q == $past(data_hold_q[SRWP_HI_POS]))
    else $error("high protect bit not taken from bit 0");
  refuse_quiet_a: assert property (in_exec && !accept
                                   |=> cmd_done && !sr_wr_pulse && $stable(hi_q) && $stable(lo_q))
    else $error("refused write changed state or did not finish");
  req_served_a: assert property ($rose(req_new) && st_q == SRWP_S_IDLE && !reset_evt
                                 |=> ##[0:2] cmd_done)
    else $error("pending request not served");
  // decision output trails the protect state by one cycle
  sw_allowed_a: assert property (!hi_q && !lo_q && !reload_busy |=> status_write_allowed)
    else $error("software-protected state not shown as writable");
  hw_closed_a: assert property (!hi_q && lo_q && !wp_high && !reload_busy
                                |=> !status_write_allowed)
    else $error("hardware-protected state shown as writable");
  lock_closed_a: assert property (hi_q |=> !status_write_allowed)
    else $error("lockdown state shown as writable");

  sw_write_c: cover property (ok_req && !hi_q && !lo_q ##1 sr_wr_pulse);
  hw_refuse_c: cover property (in_exec && lo_q && !hi_q && !wp_high);
  lockdown_release_c: cover property (hi_q && !lo_q ##1 reload_busy ##1 !hi_q);
  otp_c: cover property (hi_q && lo_q && permanent_lock_bit && in_exec);
endmodule

// >>> srwp_host_model.sv
// spi host model issuing write-status-register commands on the link clock
`timescale 1ns/1ps
module srwp_host_model (
  // link
  input wire logic spi_clk,
  input wire logic link_busy,
  output logic cmd_valid,
  output logic [7:0] cmd_opcode,
  output logic [7:0] cmd_data
);
  initial begin
    cmd_valid = 1'h0;
    cmd_opcode = 8'h00;
    cmd_data = 8'h00;
  end
  // one command in flight; a busy link would drop the request silently
  task automatic send(input logic [7:0] op, input logic [7:0] dat);
    @(posedge spi_clk);
    while (link_busy !== 1'h0) @(posedge spi_clk);
    #1;
    cmd_valid = 1'h1;
    cmd_opcode = op;
    cmd_data = dat;
    @(posedge spi_clk);
    #1;
    cmd_valid = 1'h0;
    // bytes are stale now: show the inverse rather than a usable copy
    cmd_opcode = ~op;
    cmd_data = ~dat;
  endtask
endmodule

// >>> srwp_top_tb.sv
// self-checking bench for the status register write protect block
`timescale 1ns/1ps
module srwp_top_tb;
  import srwp_pkg::*;
  logic sys_clk, spi_clk, reset, cmd_valid, link_busy, wp_pin_n, hw_reset_pin_n, sw_reset;
  logic write_enable_latch, nv_protect_mode_hi, nv_protect_mode_lo, permanent_lock_bit;
  logic protect_mode_hi, protect_mode_lo, status_write_allowed, reload_busy;
  logic cmd_done, cmd_accepted, sr_wr_pulse;
  logic [1:0] sr_wr_index;
  logic [7:0] cmd_opcode, cmd_data, sr_wr_data, pair_w;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  assign pair_w = {6'h00, protect_mode_hi, protect_mode_lo};

  srwp_top uut (
    .sys_clk(sys_clk), .reset(reset), .spi_clk(spi_clk), .cmd_valid(cmd_valid),
    .cmd_opcode(cmd_opcode), .cmd_data(cmd_data), .link_busy(link_busy),
    .wp_pin_n(wp_pin_n), .hw_reset_pin_n(hw_reset_pin_n), .sw_reset(sw_reset),
    .write_enable_latch(write_enable_latch), .nv_protect_mode_hi(nv_protect_mode_hi),
    .nv_protect_mode_lo(nv_protect_mode_lo), .permanent_lock_bit(permanent_lock_bit),
    .protect_mode_hi(protect_mode_hi), .protect_mode_lo(protect_mode_lo),
    .status_write_allowed(status_write_allowed), .reload_busy(reload_busy),
    .cmd_done(cmd_done), .cmd_accepted(cmd_accepted), .sr_wr_pulse(sr_wr_pulse),
    .sr_wr_index(sr_wr_index), .sr_wr_data(sr_wr_data)
  );
  srwp_host_model host (
    .spi_clk(spi_clk), .link_busy(link_busy), .cmd_valid(cmd_valid),
    .cmd_opcode(cmd_opcode), .cmd_data(cmd_data)
  );

  initial begin
    sys_clk = 1'h0;
    forever #2 sys_clk = ~sys_clk;
  end
  // link clock free-running, phase unrelated to the system clock
  initial begin
    spi_clk = 1'h0;
    #1.3;
    forever #6 spi_clk = ~spi_clk;
  end

  task automatic give_verdict();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    forever begin
      @(posedge sys_clk);
      cycles++;
      if (cycles == 20000) begin
        failures++;
        $display("unexpected at %0t: run did not finish", $time);
        give_verdict();
      end
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic settle();
    int n;
    n = 0;
    while (reload_busy !== 1'h0 && n < 50) begin
      idle(1);
      n++;
    end
    check({7'h00, reload_busy}, 8'h00, "reload end");
  endtask

  // open in 0,0; in 0,1 only with the pin high; never with the high bit set
  task automatic check_open(input logic [1:0] pair);
    logic want;
    want = (pair == 2'h0) || (pair == 2'h1 && wp_pin_n);
    idle(2);
    check({7'h00, status_write_allowed}, {7'h00, want}, "write allowed");
  endtask

  // nv = {hi, lo, lock}; hw selects the pin instead of the software request
  task automatic reload(input logic [2:0] nv, input logic hw, input logic [1:0] exp);
    {nv_protect_mode_hi, nv_protect_mode_lo, permanent_lock_bit} = nv;
    if (hw) hw_reset_pin_n = 1'h0;
    else sw_reset = 1'h1;
    idle(4);
    hw_reset_pin_n = 1'h1;
    sw_reset = 1'h0;
    settle();
    check(pair_w, {6'h00, exp}, "reload pair");
    check_open(exp);
  endtask

  task automatic por(input logic [2:0] nv, input logic [1:0] exp);
    {nv_protect_mode_hi, nv_protect_mode_lo, permanent_lock_bit} = nv;
    reset = 1'h1;
    idle(10);
    reset = 1'h0;
    settle();
    check(pair_w, {6'h00, exp}, "power-on pair");
    check({7'h00, link_busy}, 8'h00, "link idle after reset");
    check_open(exp);
  endtask

  task automatic wr(input logic [7:0] op, input logic [7:0] dat, input logic acc,
                    input logic [1:0] idx, input logic [1:0] pair);
    int n;
    n = 0;
    fork
      host.send(op, dat);
      begin
        idle(1);
        while (cmd_done !== 1'h1 && n < 100) begin
          idle(1);
          n++;
        end
        check({7'h00, cmd_done}, 8'h01, "done");
        check({7'h00, cmd_accepted}, {7'h00, acc}, "accept");
        check({7'h00, sr_wr_pulse}, {7'h00, acc}, "strobe");
        if (acc) begin
          check({6'h00, sr_wr_index}, {6'h00, idx}, "index");
          check(sr_wr_data, dat, "data");
        end
        check({7'h00, link_busy}, 8'h01, "link busy until ack");
        check(pair_w, {6'h00, pair}, "pair after write");
      end
    join
    check_open(pair);
  endtask

  task automatic pin(input logic v);
    wp_pin_n = v;
    // two-flop sync plus decision lag
    idle(6);
  endtask

  initial begin
    {reset, sw_reset, write_enable_latch, wp_pin_n, hw_reset_pin_n} = 5'b10111;
    {nv_protect_mode_hi, nv_protect_mode_lo, permanent_lock_bit} = 3'h0;
    por(3'b000, 2'h0);
    wr(SRWP_OP_WRSR0, 8'h00, 1'h1, SRWP_IDX_SR0, 2'h0);
    wr(SRWP_OP_WRSR3, 8'hA5, 1'h1, SRWP_IDX_SR3, 2'h0);
    wr(SRWP_OP_WRSR4, 8'h5A, 1'h1, SRWP_IDX_SR4, 2'h0);
    pin(1'h0);
    wr(SRWP_OP_WRSR2, 8'hFE, 1'h1, SRWP_IDX_SR2, 2'h0);
    write_enable_latch = 1'h0;
    wr(SRWP_OP_WRSR0, 8'h80, 1'h0, 2'h0, 2'h0);
    write_enable_latch = 1'h1;
    wr(8'h05, 8'h80, 1'h0, 2'h0, 2'h0);
    $display("test software protection done");
    wr(SRWP_OP_WRSR0, 8'h80, 1'h1, SRWP_IDX_SR0, 2'h1);
    pin(1'h0);
    wr(SRWP_OP_WRSR0, 8'h00, 1'h0, 2'h0, 2'h1);
    pin(1'h1);
    wr(SRWP_OP_WRSR3, 8'h11, 1'h1, SRWP_IDX_SR3, 2'h1);
    $display("test hardware protection done");
    wr(SRWP_OP_WRSR2, 8'h01, 1'h1, SRWP_IDX_SR2, 2'h3);
    wr(SRWP_OP_WRSR0, 8'h00, 1'h0, 2'h0, 2'h3);
    reload(3'b110, 1'h0, 2'h1);
    wr(SRWP_OP_WRSR0, 8'h00, 1'h1, SRWP_IDX_SR0, 2'h0);
    wr(SRWP_OP_WRSR2, 8'h01, 1'h1, SRWP_IDX_SR2, 2'h2);
    pin(1'h0);
    wr(SRWP_OP_WRSR2, 8'h00, 1'h0, 2'h0, 2'h2);
    reload(3'b100, 1'h1, 2'h0);
    $display("test lockdown done");
    reload(3'b001, 1'h0, 2'h0);
    reload(3'b011, 1'h1, 2'h1);
    reload(3'b111, 1'h0, 2'h3);
    pin(1'h1);
    wr(SRWP_OP_WRSR4, 8'h00, 1'h0, 2'h0, 2'h3);
    reload(3'b111, 1'h1, 2'h3);
    por(3'b111, 2'h3);
    wr(SRWP_OP_WRSR2, 8'h00, 1'h0, 2'h0, 2'h3);
    $display("test permanent lock done");
    give_verdict();
  end
endmodule
